//--- dpsm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpsm_map.svh"

module dpsm_top (
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    input  wire logic [15:0]  cmdWordIn,
    input  wire logic         cmdWrite,
    input  wire logic         initDone,
    input  wire logic         faultDetect,
    input  wire logic         faultReactionDone,
    input  wire logic         quickStopDone,
    input  wire logic [15:0]  quickStopOption,
    input  wire logic [7:0]   operatingMode,
    output logic [15:0]       driveCommandWord,
    output logic [15:0]       statusWord,
    output dpsm_pkg::dpsm_state_t drivePowerState,
    output logic              driveFunctionsEnable,
    output logic              quickStopStart,
    output logic              faultReactionStart,
    output logic              homingStart,
    output logic              newSetPoint,
    output logic              changeImmediate,
    output logic              absRelSelect,
    output logic              pauseRequest
);
    // --------------------------------------------------------------
    // State record
    // --------------------------------------------------------------
    typedef struct packed {
        dpsm_pkg::dpsm_state_t state;
        logic [15:0]           cmdWord;
        logic                  prevFaultClear;
        logic                  qsComplete;
        logic [15:0]           status;
        logic                  driveEn;
        logic                  qsStart;
        logic                  frStart;
        logic                  homing;
        logic                  newSet;
        logic                  changeImm;
        logic                  absRel;
        logic                  pause;
    } dpsm_rec_t;

    dpsm_rec_t stReg;
    dpsm_rec_t stNext;

    dpsm_cmd_if cmdBus ();

    dpsm_cmd_decode u_decode (
        .cmdBus (cmdBus)
    );

    assign cmdBus.word           = stReg.cmdWord;
    assign cmdBus.prevFaultClear = stReg.prevFaultClear;

    logic optAuto;
    logic optHold;
    logic modeHoming;
    logic modeProfile;

    assign optAuto = (quickStopOption >= `DPSM_QS_OPT_AUTO_LO) &&
                     (quickStopOption <= `DPSM_QS_OPT_AUTO_HI);
    assign optHold = (quickStopOption >= `DPSM_QS_OPT_HOLD_LO) &&
                     (quickStopOption <= `DPSM_QS_OPT_HOLD_HI);
    assign modeHoming  = (operatingMode == `DPSM_MODE_HOMING);
    assign modeProfile = (operatingMode == `DPSM_MODE_PROFILE_POS);

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        stNext         = stReg;
        stNext.qsStart = 1'b0;
        stNext.frStart = 1'b0;
        if (cmdWrite) begin
            stNext.cmdWord = cmdWordIn;
        end
        stNext.prevFaultClear = stReg.cmdWord[`DPSM_CW_FAULT_CLEAR];
        if (stReg.state == dpsm_pkg::PS_QUICK_STOP && quickStopDone) begin
            stNext.qsComplete = 1'b1;
        end

        // Errors outrank commands; init is not interruptible
        if (faultDetect && stReg.state != dpsm_pkg::PS_NOT_READY &&
            stReg.state != dpsm_pkg::PS_FAULT_REACTION &&
            stReg.state != dpsm_pkg::PS_FAULT) begin
            stNext.state   = dpsm_pkg::PS_FAULT_REACTION;
            stNext.frStart = 1'b1;
        end else begin
            // Unlisted combinations fall through and hold the state
            unique case (stReg.state)
                dpsm_pkg::PS_NOT_READY: begin
                    if (initDone) begin
                        stNext.state = dpsm_pkg::PS_SWON_DISABLED;
                    end
                end
                dpsm_pkg::PS_SWON_DISABLED: begin
                    if (cmdBus.cmd == dpsm_pkg::CMD_SHUTDOWN) begin
                        stNext.state = dpsm_pkg::PS_READY;
                    end
                end
                dpsm_pkg::PS_READY: begin
                    unique case (cmdBus.cmd)
                        dpsm_pkg::CMD_SWITCH_ON:       stNext.state = dpsm_pkg::PS_SWITCHED_ON;
                        dpsm_pkg::CMD_ENABLE_OP:       stNext.state = dpsm_pkg::PS_OP_ENABLED;
                        dpsm_pkg::CMD_DISABLE_VOLTAGE,
                        dpsm_pkg::CMD_QUICK_STOP:      stNext.state = dpsm_pkg::PS_SWON_DISABLED;
                        default:                       stNext.state = stReg.state;
                    endcase
                end
                dpsm_pkg::PS_SWITCHED_ON: begin
                    unique case (cmdBus.cmd)
                        dpsm_pkg::CMD_ENABLE_OP:       stNext.state = dpsm_pkg::PS_OP_ENABLED;
                        dpsm_pkg::CMD_SHUTDOWN:        stNext.state = dpsm_pkg::PS_READY;
                        dpsm_pkg::CMD_DISABLE_VOLTAGE,
                        dpsm_pkg::CMD_QUICK_STOP:      stNext.state = dpsm_pkg::PS_SWON_DISABLED;
                        default:                       stNext.state = stReg.state;
                    endcase
                end
                dpsm_pkg::PS_OP_ENABLED: begin
                    unique case (cmdBus.cmd)
                        dpsm_pkg::CMD_SWITCH_ON:       stNext.state = dpsm_pkg::PS_SWITCHED_ON;
                        dpsm_pkg::CMD_SHUTDOWN:        stNext.state = dpsm_pkg::PS_READY;
                        dpsm_pkg::CMD_DISABLE_VOLTAGE: stNext.state = dpsm_pkg::PS_SWON_DISABLED;
                        dpsm_pkg::CMD_QUICK_STOP: begin
                            stNext.state      = dpsm_pkg::PS_QUICK_STOP;
                            stNext.qsStart    = 1'b1;
                            stNext.qsComplete = 1'b0;
                        end
                        default:                       stNext.state = stReg.state;
                    endcase
                end
                dpsm_pkg::PS_QUICK_STOP: begin
                    if (optAuto && quickStopDone) begin
                        stNext.state = dpsm_pkg::PS_SWON_DISABLED;
                    end else if (optHold && stReg.qsComplete &&
                                 cmdBus.cmd == dpsm_pkg::CMD_DISABLE_VOLTAGE) begin
                        stNext.state = dpsm_pkg::PS_SWON_DISABLED;
                    end else if (optHold && cmdBus.cmd == dpsm_pkg::CMD_ENABLE_OP) begin
                        stNext.state = dpsm_pkg::PS_OP_ENABLED;
                    end
                end
                dpsm_pkg::PS_FAULT_REACTION: begin
                    if (faultReactionDone) begin
                        stNext.state = dpsm_pkg::PS_FAULT;
                    end
                end
                dpsm_pkg::PS_FAULT: begin
                    // A cause still present swallows the edge; clear must toggle again
                    if (cmdBus.faultClearRise && !faultDetect) begin
                        stNext.state = dpsm_pkg::PS_SWON_DISABLED;
                    end
                end
            endcase
        end

        // Outputs follow the next state so they line up with it
        stNext.driveEn = (stNext.state == dpsm_pkg::PS_OP_ENABLED) ||
                         (stNext.state == dpsm_pkg::PS_QUICK_STOP) ||
                         (stNext.state == dpsm_pkg::PS_FAULT_REACTION);
        unique case (stNext.state)
            dpsm_pkg::PS_NOT_READY:      stNext.status = `DPSM_SW_NOT_READY;
            dpsm_pkg::PS_SWON_DISABLED:  stNext.status = `DPSM_SW_SWON_DISABLED;
            dpsm_pkg::PS_READY:          stNext.status = `DPSM_SW_READY;
            dpsm_pkg::PS_SWITCHED_ON:    stNext.status = `DPSM_SW_SWITCHED_ON;
            dpsm_pkg::PS_OP_ENABLED:     stNext.status = `DPSM_SW_OP_ENABLED;
            dpsm_pkg::PS_QUICK_STOP:     stNext.status = `DPSM_SW_QUICK_STOP;
            dpsm_pkg::PS_FAULT_REACTION: stNext.status = `DPSM_SW_FAULT_REACTION;
            dpsm_pkg::PS_FAULT:          stNext.status = `DPSM_SW_FAULT;
        endcase

        // Homing and new set point bits only act while drive functions are enabled; the other mode bits and pause do not
        stNext.homing    = stNext.driveEn && modeHoming &&
                           stReg.cmdWord[`DPSM_CW_MODE_BIT4];
        stNext.newSet    = stNext.driveEn && modeProfile &&
                           stReg.cmdWord[`DPSM_CW_MODE_BIT4];
        stNext.changeImm = modeProfile && stReg.cmdWord[`DPSM_CW_MODE_BIT5];
        stNext.absRel    = modeProfile && stReg.cmdWord[`DPSM_CW_MODE_BIT6];
        stNext.pause     = stReg.cmdWord[`DPSM_CW_PAUSE];
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            stReg <= '0;
        end else begin
            stReg <= stNext;
        end
    end

    assign driveCommandWord     = stReg.cmdWord;
    assign statusWord           = stReg.status;
    assign drivePowerState      = stReg.state;
    assign driveFunctionsEnable = stReg.driveEn;
    assign quickStopStart       = stReg.qsStart;
    assign faultReactionStart   = stReg.frStart;
    assign homingStart          = stReg.homing;
    assign newSetPoint          = stReg.newSet;
    assign changeImmediate      = stReg.changeImm;
    assign absRelSelect         = stReg.absRel;
    assign pauseRequest         = stReg.pause;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    logic noFault;
    assign noFault = !faultDetect;

    init_auto_a: assert property (
        stReg.state == dpsm_pkg::PS_NOT_READY && initDone
        |=> stReg.state == dpsm_pkg::PS_SWON_DISABLED)
        else $error("init did not advance");
    shutdown_go_a: assert property (
        stReg.state == dpsm_pkg::PS_OP_ENABLED && noFault &&
        cmdBus.cmd == dpsm_pkg::CMD_SHUTDOWN
        |=> stReg.state == dpsm_pkg::PS_READY && !driveFunctionsEnable)
        else $error("shutdown from enabled wrong");
    switch_on_a: assert property (
        stReg.state == dpsm_pkg::PS_READY && noFault &&
        cmdBus.cmd == dpsm_pkg::CMD_SWITCH_ON
        |=> stReg.state == dpsm_pkg::PS_SWITCHED_ON && statusWord == `DPSM_SW_SWITCHED_ON)
        else $error("switch on wrong");
    enable_op_a: assert property (
        (stReg.state == dpsm_pkg::PS_READY || stReg.state == dpsm_pkg::PS_SWITCHED_ON) &&
        noFault && cmdBus.cmd == dpsm_pkg::CMD_ENABLE_OP
        |=> stReg.state == dpsm_pkg::PS_OP_ENABLED && driveFunctionsEnable)
        else $error("enable operation wrong");
    disable_op_a: assert property (
        stReg.state == dpsm_pkg::PS_OP_ENABLED && noFault &&
        cmdBus.cmd == dpsm_pkg::CMD_SWITCH_ON
        |=> stReg.state == dpsm_pkg::PS_SWITCHED_ON && !driveFunctionsEnable)
        else $error("disable operation wrong");
    disable_volt_a: assert property (
        (stReg.state == dpsm_pkg::PS_READY || stReg.state == dpsm_pkg::PS_SWITCHED_ON ||
         stReg.state == dpsm_pkg::PS_OP_ENABLED) && noFault &&
        cmdBus.cmd == dpsm_pkg::CMD_DISABLE_VOLTAGE
        |=> stReg.state == dpsm_pkg::PS_SWON_DISABLED)
        else $error("disable voltage wrong");
    halt_start_a: assert property (
        stReg.state == dpsm_pkg::PS_OP_ENABLED && noFault &&
        cmdBus.cmd == dpsm_pkg::CMD_QUICK_STOP
        |=> quickStopStart ##1 !quickStopStart)
        else $error("halt start pulse wrong");
    halt_auto_a: assert property (
        stReg.state == dpsm_pkg::PS_QUICK_STOP && optAuto && quickStopDone && noFault
        |=> stReg.state == dpsm_pkg::PS_SWON_DISABLED && statusWord == `DPSM_SW_SWON_DISABLED)
        else $error("halt auto exit wrong");
    halt_hold_a: assert property (
        stReg.state == dpsm_pkg::PS_QUICK_STOP && optHold && noFault &&
        cmdBus.cmd != dpsm_pkg::CMD_DISABLE_VOLTAGE && cmdBus.cmd != dpsm_pkg::CMD_ENABLE_OP
        |=> stReg.state == dpsm_pkg::PS_QUICK_STOP)
        else $error("halt hold left early");
    fault_entry_a: assert property (
        faultDetect && stReg.state != dpsm_pkg::PS_NOT_READY &&
        stReg.state != dpsm_pkg::PS_FAULT_REACTION && stReg.state != dpsm_pkg::PS_FAULT
        |=> faultReactionStart && statusWord == `DPSM_SW_FAULT_REACTION)
        else $error("fault entry wrong");
    fault_done_a: assert property (
        stReg.state == dpsm_pkg::PS_FAULT_REACTION && faultReactionDone
        |=> stReg.state == dpsm_pkg::PS_FAULT && !driveFunctionsEnable)
        else $error("fault reaction end wrong");
    fault_exit_a: assert property (
        stReg.state == dpsm_pkg::PS_FAULT && !(cmdBus.faultClearRise && noFault)
        |=> stReg.state == dpsm_pkg::PS_FAULT)
        else $error("fault left without clear edge");
    status_code_a: assert property (
        stReg.state == dpsm_pkg::PS_OP_ENABLED |-> statusWord == `DPSM_SW_OP_ENABLED)
        else $error("status code mismatch");

    enable_seen_c: cover property (
        stReg.state == dpsm_pkg::PS_SWITCHED_ON ##1 stReg.state == dpsm_pkg::PS_OP_ENABLED);
    halt_seen_c: cover property (
        stReg.state == dpsm_pkg::PS_QUICK_STOP ##1 stReg.state == dpsm_pkg::PS_SWON_DISABLED);
    fault_seen_c: cover property (
        stReg.state == dpsm_pkg::PS_FAULT ##1 stReg.state == dpsm_pkg::PS_SWON_DISABLED);
endmodule : dpsm_top

`default_nettype wire

//--- dpsm_map.svh
`ifndef DPSM_MAP_SVH
`define DPSM_MAP_SVH

// ----------------------------------------------------------------------
// Command word location and field positions
// ----------------------------------------------------------------------
`define DPSM_CMD_WORD_OFS       16'h6040
`define DPSM_CMD_WORD_RESET     16'h0000
`define DPSM_CW_SWITCH_ON       0
`define DPSM_CW_POWER_STAGE_EN  1
`define DPSM_CW_EMERG_HALT_N    2
`define DPSM_CW_RUN_ENABLE      3
`define DPSM_CW_MODE_BIT4       4
`define DPSM_CW_MODE_BIT5       5
`define DPSM_CW_MODE_BIT6       6
`define DPSM_CW_FAULT_CLEAR     7
`define DPSM_CW_PAUSE           8
`define DPSM_CW_MODE_BIT9       9

// ----------------------------------------------------------------------
// Status word codes, bits 6, 5 and 3 to 0
// ----------------------------------------------------------------------
`define DPSM_SW_NOT_READY       16'h0000
`define DPSM_SW_SWON_DISABLED   16'h0040
`define DPSM_SW_READY           16'h0021
`define DPSM_SW_SWITCHED_ON     16'h0023
`define DPSM_SW_OP_ENABLED      16'h0027
`define DPSM_SW_QUICK_STOP      16'h0007
`define DPSM_SW_FAULT_REACTION  16'h000f
`define DPSM_SW_FAULT           16'h0008

// ----------------------------------------------------------------------
// Operating mode codes and emergency halt option codes
// ----------------------------------------------------------------------
`define DPSM_MODE_PROFILE_POS   8'h01
`define DPSM_MODE_HOMING        8'h06
`define DPSM_QS_OPT_AUTO_LO     16'h0001
`define DPSM_QS_OPT_AUTO_HI     16'h0003
`define DPSM_QS_OPT_HOLD_LO     16'h0005
`define DPSM_QS_OPT_HOLD_HI     16'h0007

`endif

//--- dpsm_pkg.sv
package dpsm_pkg;

    typedef enum logic [2:0] {
        PS_NOT_READY,
        PS_SWON_DISABLED,
        PS_READY,
        PS_SWITCHED_ON,
        PS_OP_ENABLED,
        PS_QUICK_STOP,
        PS_FAULT_REACTION,
        PS_FAULT
    } dpsm_state_t;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_SHUTDOWN,
        CMD_SWITCH_ON,
        CMD_ENABLE_OP,
        CMD_DISABLE_VOLTAGE,
        CMD_QUICK_STOP
    } dpsm_cmd_t;

endpackage : dpsm_pkg

//--- dpsm_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none

interface dpsm_cmd_if;
    logic [15:0]         word;
    logic                prevFaultClear;
    dpsm_pkg::dpsm_cmd_t cmd;
    logic                faultClearRise;

    modport dec (input word, input prevFaultClear, output cmd, output faultClearRise);
    modport fsm (output word, output prevFaultClear, input cmd, input faultClearRise);
endinterface : dpsm_cmd_if

`default_nettype wire

//--- dpsm_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpsm_map.svh"

module dpsm_cmd_decode (
    dpsm_cmd_if.dec cmdBus
);
    logic faultClear;
    logic powerStageEnable;
    logic emergencyHaltN;
    logic switchOn;
    logic runEnable;

    assign faultClear       = cmdBus.word[`DPSM_CW_FAULT_CLEAR];
    assign powerStageEnable = cmdBus.word[`DPSM_CW_POWER_STAGE_EN];
    assign emergencyHaltN   = cmdBus.word[`DPSM_CW_EMERG_HALT_N];
    assign switchOn         = cmdBus.word[`DPSM_CW_SWITCH_ON];
    assign runEnable        = cmdBus.word[`DPSM_CW_RUN_ENABLE];

    assign cmdBus.faultClearRise = faultClear & ~cmdBus.prevFaultClear;

    // --------------------------------------------------------------
    // Command classes; fault clear high masks every other command
    // --------------------------------------------------------------
    always_comb begin
        if (faultClear) begin
            cmdBus.cmd = dpsm_pkg::CMD_NONE;
        end else if (!powerStageEnable) begin
            cmdBus.cmd = dpsm_pkg::CMD_DISABLE_VOLTAGE;
        end else if (!emergencyHaltN) begin
            cmdBus.cmd = dpsm_pkg::CMD_QUICK_STOP;
        end else if (!switchOn) begin
            cmdBus.cmd = dpsm_pkg::CMD_SHUTDOWN;
        end else if (!runEnable) begin
            // Same pattern serves switch on and disable operation
            cmdBus.cmd = dpsm_pkg::CMD_SWITCH_ON;
        end else begin
            cmdBus.cmd = dpsm_pkg::CMD_ENABLE_OP;
        end
    end
endmodule : dpsm_cmd_decode

`default_nettype wire

//--- dpsm_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module dpsm_master_model (
    input  wire logic        core_clk,
    output logic [15:0]      cmdWordIn,
    output logic             cmdWrite
);
    initial begin
        cmdWordIn = 16'h0000;
        cmdWrite  = 1'b0;
    end

    // Idle cycles before a write let the master pace slowly; the released word
    // shows its inverse so a late sample of it cannot pass unseen
    task automatic send(input logic [15:0] word, input int gap);
        repeat (gap) @(posedge core_clk);
        #1;
        cmdWordIn = word;
        cmdWrite  = 1'b1;
        @(posedge core_clk);
        #1;
        cmdWrite  = 1'b0;
        cmdWordIn = ~word;
    endtask : send
endmodule : dpsm_master_model

`default_nettype wire

//--- test_drive_power_state_machine.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpsm_map.svh"

module test_drive_power_state_machine;
    logic                  core_clk;
    logic                  reset_n;
    logic [15:0]           cmdWordIn;
    logic                  cmdWrite;
    logic                  initDone;
    logic                  faultDetect;
    logic                  faultReactionDone;
    logic                  quickStopDone;
    logic [15:0]           quickStopOption;
    logic [7:0]            operatingMode;
    logic [15:0]           driveCommandWord;
    logic [15:0]           statusWord;
    dpsm_pkg::dpsm_state_t drivePowerState;
    logic                  dfe;
    logic                  qsStart;
    logic                  frStart;
    logic                  homingStart;
    logic                  newSetPoint;
    logic                  changeImmediate;
    logic                  absRelSelect;
    logic                  pauseRequest;
    int                    fails = 0;
    int                    nTests = 0;
    int                    cycles = 0;

    dpsm_master_model dpsm_master_model_i (.core_clk(core_clk), .cmdWordIn(cmdWordIn),
        .cmdWrite(cmdWrite));
    dpsm_top dpsm_top_i (.core_clk(core_clk), .reset_n(reset_n), .cmdWordIn(cmdWordIn),
        .cmdWrite(cmdWrite), .initDone(initDone), .faultDetect(faultDetect),
        .faultReactionDone(faultReactionDone), .quickStopDone(quickStopDone),
        .quickStopOption(quickStopOption), .operatingMode(operatingMode),
        .driveCommandWord(driveCommandWord), .statusWord(statusWord),
        .drivePowerState(drivePowerState), .driveFunctionsEnable(dfe),
        .quickStopStart(qsStart), .faultReactionStart(frStart), .homingStart(homingStart),
        .newSetPoint(newSetPoint), .changeImmediate(changeImmediate),
        .absRelSelect(absRelSelect), .pauseRequest(pauseRequest));

    always #25 core_clk = ~core_clk;

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // Ceiling is about fifteen times the expected run length of some 200 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    // State settles one edge after the write edge
    task automatic wr(input logic [15:0] word);
        dpsm_master_model_i.send(word, 1);
        tick(1);
    endtask : wr

    task automatic st(input dpsm_pkg::dpsm_state_t s, input logic [15:0] sw);
        check({13'h0000, drivePowerState}, {13'h0000, s});
        check(statusWord, sw);
    endtask : st

    task automatic go_enabled();
        wr(16'h0006);
        wr(16'h000f);
        st(dpsm_pkg::PS_OP_ENABLED, `DPSM_SW_OP_ENABLED);
    endtask : go_enabled

    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    task automatic t_init();
        faultDetect = 1'b1;
        tick(2);
        st(dpsm_pkg::PS_NOT_READY, `DPSM_SW_NOT_READY);
        faultDetect = 1'b0;
        initDone = 1'b1;
        tick(1);
        st(dpsm_pkg::PS_SWON_DISABLED, `DPSM_SW_SWON_DISABLED);
        wr(16'h0007);
        st(dpsm_pkg::PS_SWON_DISABLED, `DPSM_SW_SWON_DISABLED);
        $display("test init finished");
    endtask : t_init

    task automatic t_cmds();
        wr(16'h0006);
        st(dpsm_pkg::PS_READY, `DPSM_SW_READY);
        wr(16'h0007);
        st(dpsm_pkg::PS_SWITCHED_ON, `DPSM_SW_SWITCHED_ON);
        wr(16'h000f);
        check({15'h0000, dfe}, 16'h0001);
        wr(16'h0007);
        st(dpsm_pkg::PS_SWITCHED_ON, `DPSM_SW_SWITCHED_ON);
        check({15'h0000, dfe}, 16'h0000);
        go_enabled();
        wr(16'h008e);
        st(dpsm_pkg::PS_OP_ENABLED, `DPSM_SW_OP_ENABLED);
        wr(16'h0006);
        st(dpsm_pkg::PS_READY, `DPSM_SW_READY);
        check({15'h0000, dfe}, 16'h0000);
        wr(16'h000f);
        wr(16'h000d);
        st(dpsm_pkg::PS_SWON_DISABLED, `DPSM_SW_SWON_DISABLED);
        check({15'h0000, dfe}, 16'h0000);
        wr(16'h0006);
        wr(16'h0002);
        st(dpsm_pkg::PS_SWON_DISABLED, `DPSM_SW_SWON_DISABLED);
        $display("test commands finished");
    endtask : t_cmds

    task automatic t_halt();
        for (int opt = 1; opt <= 7; opt++) begin
            if (opt != 4) begin
                quickStopOption = 16'(opt);
                go_enabled();
                wr(16'h000b);
                st(dpsm_pkg::PS_QUICK_STOP, `DPSM_SW_QUICK_STOP);
                check({15'h0000, qsStart}, 16'h0001);
                if (opt > 4) begin
                    wr(16'h000f);
                    st(dpsm_pkg::PS_OP_ENABLED, `DPSM_SW_OP_ENABLED);
                    wr(16'h000b);
                    wr(16'h0009);
                    st(dpsm_pkg::PS_QUICK_STOP, `DPSM_SW_QUICK_STOP);
                    wr(16'h000b);
                end else begin
                    // Start pulse lasts one cycle; let it drop before looking
                    tick(1);
                end
                check({15'h0000, qsStart}, 16'h0000);
                quickStopDone = 1'b1;
                tick(1);
                quickStopDone = 1'b0;
                if (opt > 4) begin
                    st(dpsm_pkg::PS_QUICK_STOP, `DPSM_SW_QUICK_STOP);
                    wr(16'h0009);
                end
                st(dpsm_pkg::PS_SWON_DISABLED, `DPSM_SW_SWON_DISABLED);
                check({15'h0000, dfe}, 16'h0000);
            end
        end
        $display("test halt options finished");
    endtask : t_halt

    task automatic t_fault();
        go_enabled();
        faultDetect = 1'b1;
        tick(1);
        st(dpsm_pkg::PS_FAULT_REACTION, `DPSM_SW_FAULT_REACTION);
        check({15'h0000, frStart}, 16'h0001);
        faultReactionDone = 1'b1;
        tick(1);
        faultReactionDone = 1'b0;
        st(dpsm_pkg::PS_FAULT, `DPSM_SW_FAULT);
        check({14'h0000, dfe, frStart}, 16'h0000);
        wr(16'h0080);
        st(dpsm_pkg::PS_FAULT, `DPSM_SW_FAULT);
        faultDetect = 1'b0;
        wr(16'h0000);
        st(dpsm_pkg::PS_FAULT, `DPSM_SW_FAULT);
        wr(16'h00ff);
        st(dpsm_pkg::PS_SWON_DISABLED, `DPSM_SW_SWON_DISABLED);
        check(driveCommandWord, 16'h00ff);
        wr(16'h0000);
        $display("test fault finished");
    endtask : t_fault

    task automatic t_modes();
        operatingMode = `DPSM_MODE_HOMING;
        go_enabled();
        wr(16'h001f);
        check({12'h000, homingStart, newSetPoint, changeImmediate, absRelSelect}, 16'h0008);
        operatingMode = `DPSM_MODE_PROFILE_POS;
        wr(16'h007f);
        check({12'h000, homingStart, newSetPoint, changeImmediate, absRelSelect}, 16'h0007);
        operatingMode = 8'h08;
        wr(16'h017f);
        check({11'h000, pauseRequest, homingStart, newSetPoint, changeImmediate,
               absRelSelect}, 16'h0010);
        $display("test mode bits finished");
    endtask : t_modes

    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        initDone = 1'b0;
        faultDetect = 1'b0;
        faultReactionDone = 1'b0;
        quickStopDone = 1'b0;
        quickStopOption = 16'h0002;
        operatingMode = 8'h00;
        tick(16);
        reset_n = 1'b1;
        t_init();
        t_cmds();
        t_halt();
        t_fault();
        t_modes();
        report_and_stop();
    end
endmodule : test_drive_power_state_machine

`default_nettype wire
